// [inc/sbs_pkg.sv]
package sbs_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_START = 8'h04;
   localparam logic [7:0] A_STOP = 8'h08;
   localparam logic [7:0] A_STIME = 8'h0c;
   localparam logic [7:0] A_MARK = 8'h10;
   localparam logic [7:0] A_COUNT = 8'h14;
   localparam logic [7:0] A_DLYLO = 8'h18;
   localparam logic [7:0] A_DLYHI = 8'h1c;
   localparam logic [7:0] A_TIMER = 8'h20;
   localparam logic [7:0] A_PHASE = 8'h24;
   localparam logic [7:0] A_LRATIO = 8'h28;
   localparam logic [7:0] A_CMD = 8'h2c;
   localparam logic [7:0] A_STAT = 8'h30;
   localparam logic [7:0] A_FREQ = 8'h34;
   // ==========================================================
   // control bit positions
   localparam int C_EN = 0;
   localparam int C_BURST = 1;
   localparam int C_LOG = 2;
   localparam int C_EXT = 3;
   localparam int C_GATED = 4;
   localparam int C_INF = 5;
   localparam int C_MARK = 6;
   localparam int C_TOUT = 7;
   localparam int C_NOISE = 8;
   localparam int C_FALL = 9;
   localparam int C_TIMER = 10;
   localparam int CTRL_W = 11;
   localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
   // ==========================================================
   // timing
   localparam int CLK_PS = 8000;
   localparam int DLY_UNIT_PS = 100;
   localparam logic [39:0] DLY_INC = 40'(CLK_PS / DLY_UNIT_PS);
   localparam int TOUT_NS = 450;
   localparam int CLK_NS = 8;
   localparam int TOUT_CYC = (TOUT_NS + CLK_NS - 1) / CLK_NS;
   localparam int DWELL_LOG = 6;
   localparam int LOG_FRAC = 24;
   localparam int BURST_MAX = 1000000;
   typedef enum logic [1:0] {SBS_IDLE, SBS_DELAY, SBS_RUN} sbs_state_t;
endpackage

// [rtl/sbs_core.sv]
`timescale 1ns/100ps
module sbs_core #(
   parameter int CW = 20
)(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // trigger connector and key
   input wire logic trig_in,
   output logic trig_out,
   output logic trig_oe,
   input wire logic key_in,
   // synthesizer side
   output logic sync_out,
   output logic wave_on,
   output logic [31:0] freq_out,
   output logic [31:0] phase_out
);
   // ==========================================================
   // register bus
   localparam int CTRL_W = sbs_pkg::CTRL_W;
   logic [CW-1:0] cnt_max;
   logic [CTRL_W-1:0] ctrl;
   logic [31:0] f_start, f_stop, stime, marker, tperiod, sphase, lratio;
   logic [39:0] dly;
   logic mark_err, remote, wr_pend;
   logic [7:0] wr_addr;
   logic [31:0] rd_val;
   sbs_pkg::sbs_state_t state, next_state;
   logic [31:0] f, rel, step_idx, dw_cnt;
   logic [4:0] sk;
   logic [39:0] dly_acc;
   logic [CW-1:0] bc;
   logic [7:0] tcnt;
   logic [31:0] tmr;
   logic sync_r;

   wire acc = hsel && hready && htrans[1];
   wire [31:0] f_lo = (f_start < f_stop) ? f_start : f_stop;
   wire [31:0] f_hi = (f_start < f_stop) ? f_stop : f_start;
   wire mark_ok = (hwdata >= f_lo) && (hwdata <= f_hi);
   // zero wait state, never an error
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // address phase is latched; the write lands in the data phase
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else
      begin
         wr_pend <= acc && hwrite;
         if (acc)
            wr_addr <= haddr[7:0];
      end

   // read data is captured at the address phase so it stands in the data phase
   always_comb
   begin
      rd_val = 32'h0000_0000;
      unique case (haddr[7:0])
         sbs_pkg::A_CTRL: rd_val = {21'h0, ctrl};
         sbs_pkg::A_START: rd_val = f_start;
         sbs_pkg::A_STOP: rd_val = f_stop;
         sbs_pkg::A_STIME: rd_val = stime;
         sbs_pkg::A_MARK: rd_val = marker;
         sbs_pkg::A_COUNT: rd_val = 32'(cnt_max);
         sbs_pkg::A_DLYLO: rd_val = dly[31:0];
         sbs_pkg::A_DLYHI: rd_val = {24'h0, dly[39:32]};
         sbs_pkg::A_TIMER: rd_val = tperiod;
         sbs_pkg::A_PHASE: rd_val = sphase;
         sbs_pkg::A_LRATIO: rd_val = lratio;
         sbs_pkg::A_STAT: rd_val = {27'h0, mark_err, sync_r, state == sbs_pkg::SBS_DELAY, state == sbs_pkg::SBS_RUN, 1'b0};
         sbs_pkg::A_FREQ: rd_val = f;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (acc && !hwrite)
         hrdata <= rd_val;

   // software registers; the marker takes only values inside the sweep span
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         ctrl <= sbs_pkg::CTRL_RST;
         f_start <= 32'h0000_0000;
         f_stop <= 32'h0000_0000;
         stime <= 32'h0000_0000;
         marker <= 32'h0000_0000;
         cnt_max <= CW'(1);
         dly <= 40'h00_0000_0000;
         tperiod <= 32'h0000_0000;
         sphase <= 32'h0000_0000;
         lratio <= 32'h0000_0000;
         mark_err <= 1'b0;
         remote <= 1'b0;
      end
      else
      begin
         remote <= wr_pend && wr_addr == sbs_pkg::A_CMD && hwdata[0];
         if (wr_pend)
            unique case (wr_addr)
               sbs_pkg::A_CTRL: ctrl <= hwdata[CTRL_W-1:0];
               sbs_pkg::A_START: f_start <= hwdata;
               sbs_pkg::A_STOP: f_stop <= hwdata;
               sbs_pkg::A_STIME: stime <= hwdata;
               sbs_pkg::A_MARK:
               begin
                  if (mark_ok)
                     marker <= hwdata;
                  mark_err <= !mark_ok;
               end
               sbs_pkg::A_COUNT:
                  if (hwdata == 32'h0)
                     cnt_max <= CW'(1);
                  else if (hwdata > 32'(sbs_pkg::BURST_MAX))
                     cnt_max <= CW'(sbs_pkg::BURST_MAX);
                  else
                     cnt_max <= hwdata[CW-1:0];
               sbs_pkg::A_DLYLO: dly[31:0] <= hwdata;
               sbs_pkg::A_DLYHI: dly[39:32] <= hwdata[7:0];
               sbs_pkg::A_TIMER: tperiod <= hwdata;
               sbs_pkg::A_PHASE: sphase <= hwdata;
               sbs_pkg::A_LRATIO: lratio <= hwdata;
               default: ;
            endcase
      end

   wire en = ctrl[sbs_pkg::C_EN];
   wire burst = ctrl[sbs_pkg::C_BURST];
   wire ext = ctrl[sbs_pkg::C_EXT];
   wire gated = burst && ctrl[sbs_pkg::C_GATED];
   wire inf = ctrl[sbs_pkg::C_INF];

   // ==========================================================
   // trigger sources
   logic [1:0] ti_s, key_s;
   logic lvl_d, key_d;
   // pins pass two flops before anything looks at them
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         ti_s <= 2'b00;
         key_s <= 2'b00;
         lvl_d <= 1'b0;
         key_d <= 1'b0;
      end
      else
      begin
         ti_s <= {ti_s[0], trig_in};
         key_s <= {key_s[0], key_in};
         lvl_d <= ti_s[1] ^ ctrl[sbs_pkg::C_FALL];
         key_d <= key_s[1];
      end

   wire gate = (ti_s[1] ^ ctrl[sbs_pkg::C_FALL]) && !trig_oe;
   wire ext_edge = gate && !lvl_d;
   wire key_edge = key_s[1] && !key_d;
   wire tmr_hit = burst && ctrl[sbs_pkg::C_TIMER] && en && (tmr + 32'h1 >= tperiod);
   // pin edges count only when the connector is an input
   wire trig_any = (ext && ext_edge) || key_edge || remote || tmr_hit;

   // internal burst timer free-runs while selected
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         tmr <= 32'h0000_0000;
      else if (tmr_hit || !(burst && ctrl[sbs_pkg::C_TIMER] && en))
         tmr <= 32'h0000_0000;
      else
         tmr <= tmr + 32'h1;

   // ==========================================================
   // sweep step geometry: dwell stays near 2^DWELL_LOG, longer time means more steps
   logic [4:0] msb, k;
   always_comb
   begin
      msb = 5'h00;
      for (int i = 0; i < 32; i++)
         if (stime[i])
            msb = i[4:0];
      k = (msb > 5'(sbs_pkg::DWELL_LOG)) ? msb - 5'(sbs_pkg::DWELL_LOG) : 5'h00;
   end

   wire up = f_stop >= f_start;
   wire [31:0] dwell = stime >> sk;
   wire [31:0] n_steps = 32'h1 << sk;
   wire signed [32:0] diff = $signed({1'b0, f_stop}) - $signed({1'b0, f_start});
   wire signed [32:0] inc = diff >>> sk;
   wire [63:0] prod = f * lratio;
   wire [31:0] lstep = prod[sbs_pkg::LOG_FRAC+31:sbs_pkg::LOG_FRAC];
   wire run = state == sbs_pkg::SBS_RUN;
   wire step_adv = run && !burst && (dw_cnt + 32'h1 >= dwell);
   wire sweep_end = step_adv && (step_idx + 32'h1 >= n_steps);
   wire reached = up ? f >= marker : f <= marker;
   wire [32:0] rel_sum = {1'b0, rel} + {1'b0, f};
   wire wrap = run && rel_sum[32];
   wire burst_done = !inf && wrap && (bc + CW'(1) >= cnt_max);
   wire dly_done = dly_acc >= dly;

   // ==========================================================
   // sequencer
   logic go;
   always_comb
   begin
      next_state = state;
      go = 1'b0;
      unique case (state)
         sbs_pkg::SBS_IDLE:
            if (en)
            begin
               if (gated)
               begin
                  if (gate)
                  begin
                     next_state = sbs_pkg::SBS_RUN;
                     go = 1'b1;
                  end
               end
               else if (!burst && !ext)
               begin
                  next_state = sbs_pkg::SBS_RUN;
                  go = 1'b1;
               end
               else if (trig_any)
                  next_state = sbs_pkg::SBS_DELAY;
            end
         sbs_pkg::SBS_DELAY:
            if (!en)
               next_state = sbs_pkg::SBS_IDLE;
            else if (dly_done)
            begin
               next_state = sbs_pkg::SBS_RUN;
               go = 1'b1;
            end
         sbs_pkg::SBS_RUN:
            // triggers are not looked at here, so a busy sequence drops them
            if (!en)
               next_state = sbs_pkg::SBS_IDLE;
            else if (gated)
            begin
               if (!gate && (ctrl[sbs_pkg::C_NOISE] || wrap))
                  next_state = sbs_pkg::SBS_IDLE;
            end
            else if (burst)
            begin
               if (burst_done)
                  next_state = sbs_pkg::SBS_IDLE;
            end
            else if (sweep_end)
            begin
               if (ext)
                  next_state = sbs_pkg::SBS_IDLE;
               else
                  go = 1'b1;
            end
         // the fourth code of the state word is never entered; fall back to idle
         default: next_state = sbs_pkg::SBS_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         state <= sbs_pkg::SBS_IDLE;
      else
         state <= next_state;

   // delay counted in 100 ps units, 80 of them per clock
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         dly_acc <= 40'h00_0000_0000;
      else if (state == sbs_pkg::SBS_DELAY)
         dly_acc <= dly_acc + sbs_pkg::DLY_INC;
      else
         dly_acc <= 40'h00_0000_0000;

   // ==========================================================
   // frequency and sweep position
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         f <= 32'h0000_0000;
         sk <= 5'h00;
         step_idx <= 32'h0000_0000;
         dw_cnt <= 32'h0000_0000;
      end
      else if (go || !run)
      begin
         f <= f_start;
         sk <= k;
         step_idx <= 32'h0000_0000;
         dw_cnt <= 32'h0000_0000;
      end
      else if (step_adv)
      begin
         dw_cnt <= 32'h0000_0000;
         step_idx <= step_idx + 32'h1;
         if (!ctrl[sbs_pkg::C_LOG])
            f <= f + inc[31:0];
         else
            f <= up ? f + lstep : f - lstep;
      end
      else if (!burst)
         dw_cnt <= dw_cnt + 32'h1;

   // sync marks sweep start, then falls at midpoint or marker
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         sync_r <= 1'b0;
      else if (go && !burst)
         sync_r <= 1'b1;
      else if (!run || burst)
         sync_r <= 1'b0;
      else if (ctrl[sbs_pkg::C_MARK] && reached)
         sync_r <= 1'b0;
      else if (!ctrl[sbs_pkg::C_MARK] && step_adv && step_idx + 32'h1 >= (n_steps >> 1))
         sync_r <= 1'b0;

   // ==========================================================
   // waveform phase; idle holds the start phase point
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         rel <= 32'h0000_0000;
         bc <= '0;
      end
      else if (go || !run)
      begin
         rel <= 32'h0000_0000;
         bc <= '0;
      end
      else
      begin
         rel <= rel_sum[31:0];
         if (wrap)
            bc <= bc + CW'(1);
      end

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         phase_out <= 32'h0000_0000;
         freq_out <= 32'h0000_0000;
         wave_on <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         phase_out <= rel + sphase;
         freq_out <= f;
         wave_on <= run;
         sync_out <= sync_r;
      end

   // trigger out: stretched pulse on each run start (go), gated runs excluded
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         tcnt <= 8'h00;
      else if (go && !gated)
         tcnt <= 8'(sbs_pkg::TOUT_CYC);
      else if (tcnt != 8'h00)
         tcnt <= tcnt - 8'h01;

   assign trig_oe = ctrl[sbs_pkg::C_TOUT];
   assign trig_out = trig_oe && tcnt != 8'h00;

   // ==========================================================
   // checks
   sequence s_tout_pulse;
      trig_out [*8];
   endsequence

   a_tout_width: assert property (@(posedge hclk) disable iff (!hresetn)
      (go && !gated && trig_oe) |=> s_tout_pulse) else $error("trigger out too short");
   a_sync_start: assert property (@(posedge hclk) disable iff (!hresetn)
      (go && !burst) |-> ##1 sync_r ##1 sync_out) else $error("sync not raised at sweep start");
   a_sync_mid: assert property (@(posedge hclk) disable iff (!hresetn)
      (run && !burst && !go && !ctrl[sbs_pkg::C_MARK] && step_adv && step_idx + 32'h1 == (n_steps >> 1))
      |=> !sync_r) else $error("sync not low at midpoint");
   a_sync_mark: assert property (@(posedge hclk) disable iff (!hresetn)
      (run && !burst && !go && ctrl[sbs_pkg::C_MARK] && reached) |=> !sync_r) else $error("sync missed marker");
   a_mark_range: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_pend && wr_addr == sbs_pkg::A_MARK && !mark_ok) |=> $stable(marker) && mark_err)
      else $error("marker outside span accepted");
   a_burst_end: assert property (@(posedge hclk) disable iff (!hresetn)
      (run && en && burst && !gated && burst_done) |=> state == sbs_pkg::SBS_IDLE
      ##1 phase_out == $past(rel_sum[31:0], 2) + $past(sphase, 2) ##1 phase_out == $past(sphase, 3))
      else $error("burst did not stop on count");
   a_delay_go: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == sbs_pkg::SBS_DELAY && en && dly_done) |=> run && rel == 32'h0) else $error("delay expiry did not start");
   a_busy_drop: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == sbs_pkg::SBS_DELAY && en && !dly_done && trig_any) |=> dly_acc == $past(dly_acc) + sbs_pkg::DLY_INC)
      else $error("trigger restarted a running delay");
   a_noise_stop: assert property (@(posedge hclk) disable iff (!hresetn)
      (run && en && gated && ctrl[sbs_pkg::C_NOISE] && !gate) |=> state == sbs_pkg::SBS_IDLE ##1 !wave_on)
      else $error("noise gate did not stop at once");
   a_idle_phase: assert property (@(posedge hclk) disable iff (!hresetn)
      (!run && $past(!run) && $stable(sphase)) |=> phase_out == $past(sphase)) else $error("idle phase not start phase");
endmodule

// [verification/sbs_trig_src.sv]
`timescale 1ns/100ps
// ==========================================
// far-side trigger source on the shared trigger line
module sbs_trig_src (
   // clock
   input wire logic hclk,
   // requests from the bench
   input wire logic fire,
   input wire logic gate,
   // connector drive
   output logic pin
);
   int cnt = 0;
   // one pulse per request, 13 cycles so it clears the minimum width
   always @(posedge hclk)
   begin
      if (fire)
         cnt <= 13;
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
   // gate level is held for as long as output is wanted
   assign pin = gate | (cnt > 0);
endmodule

// [verification/sweep_burst_sequencer_tb_top.sv]
`timescale 1ns/100ps
// ==========================================
// bench for the sweep and burst sequencer
module sweep_burst_sequencer_tb_top;
   logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, key_in = 0, fire = 0, gate = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, freq_out, phase_out;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, trig_out, trig_oe, sync_out, wave_on, pin, trig_in;
   int fail_count = 0, checked = 0;
   logic [31:0] seed = 32'hee37a0e9;
   // clock, 8 ns period
   always #4 hclk = ~hclk;
   // connector level: the block wins while it drives, else the far side
   assign trig_in = trig_oe ? trig_out : pin;
   sbs_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .trig_in(trig_in), .trig_out(trig_out), .trig_oe(trig_oe),
      .key_in(key_in), .sync_out(sync_out), .wave_on(wave_on), .freq_out(freq_out),
      .phase_out(phase_out));
   sbs_trig_src SRC (.hclk(hclk), .fire(fire), .gate(gate), .pin(pin));
   // ==========================================
   // helpers
   function logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
   endfunction
   // a marker value inside the programmed span, so that it is not refused
   function logic [31:0] span_mid(input logic [31:0] a, input logic [31:0] b);
      return (a < b) ? a + ((b - a) >> 1) : b + ((a - b) >> 1);
   endfunction
   function logic sig(input int s);
      return (s == 0) ? sync_out : (s == 1) ? wave_on : trig_out;
   endfunction
   task end_of_test;
      $display("checks %0d errors %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // n counts cycles until the signal shows v; a must-wait that runs out ends the run
   task waitfor(input int s, input logic v, input int lim, input bit must, output int n);
      n = 0;
      while (sig(s) !== v && n < lim)
      begin
         @(posedge hclk);
         n++;
      end
      if (must && n >= lim)
      begin
         fail_count++;
         end_of_test;
      end
   endtask
   task rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         fail_count++;
         end_of_test;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h0, a};
      hwrite <= 1'b1;
      htrans <= 2'b10;
      rdy;
      htrans <= 2'b00;
      hwdata <= d;
      rdy;
   endtask
   // idle cycle first: a read right after a write would see the old value
   task rchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge hclk);
      haddr <= {24'h0, a};
      hwrite <= 1'b0;
      htrans <= 2'b10;
      rdy;
      htrans <= 2'b00;
      rdy;
      chk(hrdata, exp);
   endtask
   task cmd_wait(output int n);
      wr(sbs_pkg::A_CMD, 32'h1);
      waitfor(1, 1'b1, 400, 1, n);
   endtask
   // ==========================================
   // main sequence
   initial
   begin
      int n, m;
      logic [31:0] v, lo, hi;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      chk(trig_oe, 0);
      rchk(sbs_pkg::A_COUNT, 32'h1);
      rchk(sbs_pkg::A_STAT, 32'h0);
      wr(8'h3c, 32'h5a5a5a5a);
      rchk(8'h3c, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         v = (i == 3) ? span_mid(lo, hi) : seed;
         if (i == 0)
            lo = v;
         if (i == 1)
            hi = v;
         wr(8'h04 + 8'(i * 4), v);
         rchk(8'h04 + 8'(i * 4), v);
      end
      // internal linear sweep: two steps of 64 cycles, trigger out on
      wr(sbs_pkg::A_START, 32'd1000);
      wr(sbs_pkg::A_STOP, 32'd11000);
      wr(sbs_pkg::A_STIME, 32'd128);
      wr(sbs_pkg::A_CTRL, 32'h81);
      waitfor(2, 1'b1, 100, 1, n);
      chk(trig_oe, 1);
      waitfor(2, 1'b0, 100, 1, n);
      chk(32'(n), 32'd57);
      chk(sync_out, 1);
      waitfor(0, 1'b0, 100, 1, n);
      repeat (2) @(posedge hclk);
      chk(freq_out, 32'd6000);
      waitfor(0, 1'b1, 200, 1, n);
      repeat (2) @(posedge hclk);
      chk(freq_out, 32'd1000);
      // let the restart's trigger pulse finish before the pin drive is switched off
      waitfor(2, 1'b0, 100, 1, n);
      // log sweep: each step adds f times the ratio, so a ratio of 1.0 doubles
      wr(sbs_pkg::A_CTRL, 32'h0);
      wr(sbs_pkg::A_LRATIO, 32'h01000000);
      wr(sbs_pkg::A_CTRL, 32'h5);
      waitfor(0, 1'b1, 100, 1, n);
      waitfor(0, 1'b0, 200, 1, n);
      repeat (2) @(posedge hclk);
      chk(freq_out, 32'd2000);
      // marker: four steps 1000, 3500, 6000, 8500; out-of-range mark refused
      wr(sbs_pkg::A_CTRL, 32'h0);
      wr(sbs_pkg::A_STIME, 32'd256);
      wr(sbs_pkg::A_MARK, 32'd3500);
      wr(sbs_pkg::A_MARK, 32'd20000);
      chk(hresp, 32'h0);
      rchk(sbs_pkg::A_MARK, 32'd3500);
      rchk(sbs_pkg::A_STAT, 32'h10);
      wr(sbs_pkg::A_CTRL, 32'h41);
      waitfor(0, 1'b1, 100, 1, n);
      waitfor(0, 1'b0, 300, 1, n);
      repeat (2) @(posedge hclk);
      chk(freq_out, 32'd3500);
      // external sweep: nothing without a pulse, one sweep per pulse
      wr(sbs_pkg::A_CTRL, 32'h0);
      wr(sbs_pkg::A_CTRL, 32'h9);
      waitfor(0, 1'b1, 300, 0, n);
      chk(32'(n), 32'd300);
      fire <= 1'b1;
      @(posedge hclk);
      fire <= 1'b0;
      waitfor(0, 1'b1, 50, 1, n);
      waitfor(0, 1'b0, 300, 1, n);
      waitfor(0, 1'b1, 800, 0, n);
      chk(32'(n), 32'd800);
      key_in <= 1'b1;
      repeat (4) @(posedge hclk);
      key_in <= 1'b0;
      waitfor(0, 1'b1, 50, 1, n);
      chk(sync_out, 1);
      // n-cycle bursts: a carry every 4 cycles, key pressed in mid-burst
      seed = lfsr(seed);
      v = seed;
      wr(sbs_pkg::A_CTRL, 32'h0);
      wr(sbs_pkg::A_START, 32'h40000000);
      wr(sbs_pkg::A_PHASE, v);
      wr(sbs_pkg::A_COUNT, 32'd1);
      wr(sbs_pkg::A_CTRL, 32'h3);
      cmd_wait(n);
      waitfor(1, 1'b0, 100, 1, n);
      wr(sbs_pkg::A_COUNT, 32'd3);
      fork
         begin
            cmd_wait(m);
            waitfor(1, 1'b0, 100, 1, m);
         end
         begin
            repeat (8) @(posedge hclk);
            key_in <= 1'b1;
            repeat (4) @(posedge hclk);
            key_in <= 1'b0;
         end
      join
      chk(32'(m - n), 32'd8);
      waitfor(1, 1'b1, 60, 0, n);
      chk(32'(n), 32'd60);
      chk(phase_out, v);
      // trigger delay: 800 units of 100 ps add ten cycles over zero
      wr(sbs_pkg::A_COUNT, 32'd1);
      cmd_wait(n);
      waitfor(1, 1'b0, 100, 1, m);
      wr(sbs_pkg::A_DLYLO, 32'd800);
      // a key press while the delay runs must neither restart nor stretch it
      fork
         cmd_wait(m);
         begin
            repeat (4) @(posedge hclk);
            key_in <= 1'b1;
            repeat (4) @(posedge hclk);
            key_in <= 1'b0;
         end
      join
      chk(32'(m - n), 32'd10);
      waitfor(1, 1'b0, 100, 1, m);
      wr(sbs_pkg::A_DLYLO, 32'd0);
      // infinite count keeps running
      wr(sbs_pkg::A_CTRL, 32'h23);
      cmd_wait(n);
      waitfor(1, 1'b0, 300, 0, n);
      chk(32'(n), 32'd300);
      // internal timer restarts bursts
      wr(sbs_pkg::A_CTRL, 32'h0);
      wr(sbs_pkg::A_TIMER, 32'd300);
      wr(sbs_pkg::A_CTRL, 32'h403);
      waitfor(1, 1'b1, 400, 1, n);
      waitfor(1, 1'b0, 100, 1, n);
      waitfor(1, 1'b1, 400, 1, n);
      chk(wave_on, 1);
      // gated: a 256-cycle waveform finishes its cycle, noise stops at once
      wr(sbs_pkg::A_CTRL, 32'h0);
      wr(sbs_pkg::A_START, 32'h01000000);
      for (int k = 0; k < 2; k++)
      begin
         wr(sbs_pkg::A_CTRL, k ? 32'h113 : 32'h13);
         gate <= 1'b1;
         waitfor(1, 1'b1, 50, 1, n);
         repeat (100) @(posedge hclk);
         chk(wave_on, 1);
         gate <= 1'b0;
         waitfor(1, 1'b0, k ? 12 : 300, 1, n);
         chk(k ? (n < 6) : (n > 20), 1);
         repeat (3) @(posedge hclk);
         chk(phase_out, v);
      end
      end_of_test;
   end
endmodule
